// ==== bench/pmc_host_model.sv ====
// host side model: uart control lines and usb bus state
`timescale 1ns/1ps
module pmc_host_model (
    // clock
    input wire logic core_clk_i,
    // wake requests from the device
    input wire logic ring_ind_i,
    input wire logic usb_rwake_i,
    // host pins
    output logic dtr_o,
    output logic rf_disable_b_o,
    output logic host_ready_o,
    output logic usb_vbus_o,
    output logic usb_suspend_o,
    output logic usb_rx_activity_o
);
    // ----------------------------------------
    // pin levels and wake bookkeeping
    // ----------------------------------------
    int wakes = 0;
    logic wake_q = 1'b0;
    // idle levels: dtr and rf-disable sit on pull-ups
    initial begin
        {dtr_o, rf_disable_b_o} = 2'b11;
        {host_ready_o, usb_vbus_o, usb_suspend_o} = 3'b010;
        usb_rx_activity_o = 1'b0;
    end
    // rising edges of the two wake lines ored together, for the bench to inspect
    always @(posedge core_clk_i) begin
        wake_q <= ring_ind_i | usb_rwake_i;
        if ((ring_ind_i | usb_rwake_i) && !wake_q)
            wakes++;
    end
    // order {dtr, rf_disable_b, ready, vbus, suspend, rx}; a slow
    // host lets dly extra edges pass before the pins move
    task automatic pins(input logic [5:0] p, input int dly);
        @(posedge core_clk_i);
        repeat (dly) @(posedge core_clk_i);
        {dtr_o, rf_disable_b_o, host_ready_o} <= p[5:3];
        {usb_vbus_o, usb_suspend_o, usb_rx_activity_o} <= p[2:0];
    endtask : pins
endmodule : pmc_host_model

// ==== bench/tb.sv ====
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module tb;
    import pmc_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam int RWC = 20;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'h0;
    logic urc = 1'b0;
    logic rfc = 1'b0;
    logic [11:0] vbb = 12'ha5c;
    logic [31:0] rdat;
    logic [31:0] rv;
    logic wreq, irq, ri, rwk, slp, hasl, rej;
    wire [3:0] en4;
    logic dtr, rfb, rdy, vb, sus, rxa;
    int error_cnt = 0;
    int check_count = 0;
    always #4 clk = ~clk;
    pmc_power_mode_controller #(.RWAKE_CYC(RWC)) dut (
        .core_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .avs_irq_o(irq), .dtr_i(dtr),
        .rf_disable_b_i(rfb), .host_ready_in_i(rdy), .usb_vbus_i(vb),
        .usb_suspend_i(sus), .usb_rx_activity_i(rxa),
        .urc_pending_i(urc), .rf_cmd_i(rfc), .baseband_supply_i(vbb),
        .ring_ind_o(ri), .usb_rwake_o(rwk), .rf_en_o(en4[3]),
        .sim_en_o(en4[2]), .serial_en_o(en4[1]), .sw_run_o(en4[0]),
        .sleep_o(slp), .host_asleep_o(hasl), .rf_cmd_reject_o(rej));
    pmc_host_model hm (
        .core_clk_i(clk), .ring_ind_i(ri), .usb_rwake_i(rwk),
        .dtr_o(dtr), .rf_disable_b_o(rfb), .host_ready_o(rdy),
        .usb_vbus_o(vb), .usb_suspend_o(sus), .usb_rx_activity_o(rxa));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic cb(input logic s, input logic e);
        chk({31'h0, s}, {31'h0, e});
    endtask : cb
    // ends off the edge so outputs are settled when looked at
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : wt
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wd <= d;
        be <= b;
        wr <= w;
        rd <= ~w;
        // waitrequest as sampled at each edge, before the edge moves it
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 64);
        if (n >= 64)
            chk(32'h1, 32'h0);
        rv = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        // settle off the edge before outputs are looked at
        @(negedge clk);
    endtask : bus
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask : wr32
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(rv, e);
    endtask : rdc
    task automatic st(input logic [2:0] s);
        bus(1'b0, PMC_STAT_ADDR, 32'h0, 4'hf);
        chk(rv & 32'h7, {29'h0, s});
    endtask : st
    task automatic complete_run();
        if (error_cnt == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk({28'h0, en4}, 32'hf);
        cb(slp, 1'b0);
        rdc(PMC_FUNC_ADDR, 32'h1);
        rdc(PMC_CTRL_ADDR, 32'h0);
        wr32(8'h1c, 32'hffffffff);
        rdc(8'h1c, 32'h0);
        rdc(PMC_VOLT_ADDR, 32'ha5c);
        @(posedge clk) vbb <= 12'h3c1;
        rdc(PMC_VOLT_ADDR, 32'h3c1);
        st(PMC_ST_FULL);
    endtask : t_reset
    task automatic t_uart();
        wr32(PMC_MASK_ADDR, 32'h1);
        wt(8);
        cb(slp, 1'b0);
        wr32(PMC_CTRL_ADDR, 32'h1);
        wt(8);
        cb(slp, 1'b1);
        st(PMC_ST_SLEEP);
        rdc(PMC_IRQ_ADDR, 32'h1);
        cb(irq, 1'b1);
        wr32(PMC_MASK_ADDR, 32'h0);
        wt(2);
        cb(irq, 1'b0);
        wr32(PMC_IRQ_ADDR, 32'h1);
        wr32(PMC_MASK_ADDR, 32'h1);
        wt(2);
        cb(irq, 1'b0);
        @(posedge clk) urc <= 1'b1;
        wt(8);
        cb(ri, 1'b1);
        @(posedge clk) urc <= 1'b0;
        hm.pins(6'b010100, 5);
        wt(8);
        cb(slp, 1'b0);
        rdc(PMC_IRQ_ADDR, 32'h2);
        wr32(PMC_IRQ_ADDR, 32'h7);
        wr32(PMC_CTRL_ADDR, 32'h0);
        hm.pins(6'b110100, 0);
    endtask : t_uart
    task automatic t_ready();
        for (int i = 0; i < 4; i++) begin
            wr32(PMC_CTRL_ADDR, {29'h0, i[1], 2'h0});
            hm.pins({2'b11, i[0], 3'b100}, 0);
            wt(8);
            cb(hasl, i[0] ^ i[1]);
        end
    endtask : t_ready
    task automatic t_usb();
        int n;
        int k;
        n = 0;
        k = 0;
        wr32(PMC_CTRL_ADDR, 32'h11);
        wt(8);
        cb(slp, 1'b0);
        hm.pins(6'b110110, 0);
        wt(8);
        cb(slp, 1'b1);
        @(posedge clk) urc <= 1'b1;
        while (rwk !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        while (rwk === 1'b1 && n < 64) begin
            @(negedge clk);
            n++;
        end
        chk(n, RWC);
        cb(ri, 1'b0);
        @(posedge clk) urc <= 1'b0;
        // traffic held while the bus still reads suspended
        hm.pins(6'b110111, 0);
        wt(8);
        cb(slp, 1'b0);
        wr32(PMC_CTRL_ADDR, 32'h10);
        hm.pins(6'b110100, 0);
        wr32(PMC_CTRL_ADDR, 32'h21);
        @(posedge clk) urc <= 1'b1;
        wt(8);
        cb(ri, 1'b1);
        cb(rwk, 1'b0);
        @(posedge clk) urc <= 1'b0;
        chk(hm.wakes, 32'h3);
        wr32(PMC_CTRL_ADDR, 32'h31);
        wt(8);
        cb(slp, 1'b0);
        hm.pins(6'b110000, 0);
        wt(8);
        cb(slp, 1'b1);
        hm.pins(6'b110100, 0);
        wt(8);
        cb(slp, 1'b0);
        wr32(PMC_CTRL_ADDR, 32'h0);
    endtask : t_usb
    task automatic t_air();
        hm.pins(6'b100100, 0);
        wt(8);
        cb(en4[3], 1'b1);
        wr32(PMC_CTRL_ADDR, 32'h2);
        wt(8);
        cb(en4[3], 1'b0);
        st(PMC_ST_AIR);
        hm.pins(6'b110100, 0);
        wt(8);
        cb(en4[3], 1'b1);
        wr32(PMC_CTRL_ADDR, 32'h0);
    endtask : t_air
    task automatic t_func();
        logic [2:0] lv [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
        logic [2:0] fx [4] = '{3'h0, 3'h4, 3'h4, 3'h1};
        logic [3:0] ex [4] = '{4'h3, 4'h7, 4'h7, 4'hf};
        wr32(PMC_IRQ_ADDR, 32'h7);
        @(posedge clk) rfc <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr32(PMC_FUNC_ADDR, {29'h0, lv[i]});
            wt(4);
            rdc(PMC_FUNC_ADDR, {29'h0, fx[i]});
            chk({28'h0, en4}, {28'h0, ex[i]});
            if (fx[i] != 3'h0)
                cb(rej, fx[i] == 3'h4);
        end
        @(posedge clk) rfc <= 1'b0;
        rdc(PMC_IRQ_ADDR, 32'h4);
    endtask : t_func
    task automatic t_down();
        bus(1'b1, PMC_CTRL_ADDR, 32'h100, 4'h2);
        wt(4);
        cb(en4[1], 1'b1);
        bus(1'b1, PMC_CTRL_ADDR, 32'h100, 4'h3);
        wt(4);
        chk({30'h0, en4[1:0]}, 32'h0);
        st(PMC_ST_DOWN);
    endtask : t_down
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        wt(4);
        t_reset();
        t_uart();
        t_ready();
        t_usb();
        t_air();
        t_func();
        t_down();
        complete_run();
    end
    // far beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule : tb

// ==== hdl/pmc_pkg.sv ====
// package of constants and types for the power mode controller
package pmc_pkg;
    // ------------------------------------------------------------
    // register byte addresses (word aligned)
    // ------------------------------------------------------------
    localparam logic [7:0] PMC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] PMC_FUNC_ADDR = 8'h04;
    localparam logic [7:0] PMC_STAT_ADDR = 8'h08;
    localparam logic [7:0] PMC_IRQ_ADDR = 8'h0c;
    localparam logic [7:0] PMC_MASK_ADDR = 8'h10;
    localparam logic [7:0] PMC_VOLT_ADDR = 8'h14;
    localparam logic [7:0] PMC_CMD_ADDR = 8'h18;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int PMC_CTRL_SLEEP_EN_BIT = 0;
    localparam int PMC_CTRL_PIN_AIR_EN_BIT = 1;
    localparam int PMC_CTRL_RDY_POL_BIT = 2;
    localparam int PMC_CTRL_USB_MODE_LSB = 4;
    localparam int PMC_CTRL_PWRDN_BIT = 8;
    localparam logic [8:0] PMC_CTRL_RST = 9'h000;
    // ------------------------------------------------------------
    // functionality levels
    // ------------------------------------------------------------
    localparam logic [2:0] PMC_FUN_MIN = 3'h0;
    localparam logic [2:0] PMC_FUN_FULL = 3'h1;
    localparam logic [2:0] PMC_FUN_AIR = 3'h4;
    // ------------------------------------------------------------
    // irq status bits
    // ------------------------------------------------------------
    localparam int PMC_IRQ_SLEEP_BIT = 0;
    localparam int PMC_IRQ_WAKE_BIT = 1;
    localparam int PMC_IRQ_REJ_BIT = 2;
    localparam int PMC_IRQ_W = 3;
    localparam int PMC_DATA_W = 32;
    localparam int PMC_VOLT_W = 12;
    // ------------------------------------------------------------
    // remote wakeup pulse, 1 ms minimum on the bus
    // ------------------------------------------------------------
    localparam int PMC_CLK_MHZ = 125;
    localparam int PMC_RWAKE_US = 1000;
    localparam int PMC_RWAKE_CYC = PMC_RWAKE_US * PMC_CLK_MHZ;
    // ------------------------------------------------------------
    // usb attachment modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PMC_USB_NONE,
        PMC_USB_RWAKE,
        PMC_USB_RI,
        PMC_USB_NOSUSP
    } pmc_usb_mode_t;
    typedef enum logic [2:0] {
        PMC_ST_FULL,
        PMC_ST_MIN,
        PMC_ST_AIR,
        PMC_ST_SLEEP,
        PMC_ST_DOWN
    } pmc_state_t;
endpackage : pmc_pkg

// ==== hdl/pmc_power_mode_controller.sv ====
// power mode controller: sleep, airplane, minimum and power-down modes
`timescale 1ns/1ps
// How it works
// (RULE_01) uart mode sleeps only with sleep enable set and ready line high
// (RULE_02) ready line driven low wakes the device from sleep
// (RULE_03) uart mode raises ring indication while a result is pending
// (RULE_04) host ready input polarity selectable; shows host sleep state
// (RULE_05) usb modes except no-suspend also need bus suspend before sleep entry
// (RULE_06) remote wakeup pulse on bus when host supports it and result pends
// (RULE_07) usb traffic wakes the device from sleep
// (RULE_08) suspend-only hosts get ring indication instead of bus signalling
// (RULE_09) no-suspend hosts drop bus power to allow sleep; restore wakes
// (RULE_10) pin airplane enabled and rf-disable low forces airplane mode unless the level is minimum
// (RULE_11) rf-disable pin ignored after reset until enabled by command
// (RULE_12) functionality levels 0 min, 1 full, 4 airplane; full by default
// (RULE_13) minimum mode turns off radio and subscriber card, power stays
// (RULE_14) airplane mode turns radio off and rejects radio commands
// (RULE_15) positioning enable is never touched by functionality changes
// (RULE_16) power-down keeps serial port off and software halted
// (RULE_17) baseband supply voltage readable by the host
// (RULE_18) ready input treated as high when left open (pull-up); the synchroniser resets ready low
// (RULE_19) all pin inputs pass two flip-flops before use
module pmc_power_mode_controller #(
    parameter int RWAKE_CYC = pmc_pkg::PMC_RWAKE_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [pmc_pkg::PMC_DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [pmc_pkg::PMC_DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic avs_irq_o,
    // pins from host
    input wire logic dtr_i,
    input wire logic rf_disable_b_i,
    input wire logic host_ready_in_i,
    input wire logic usb_vbus_i,
    input wire logic usb_suspend_i,
    input wire logic usb_rx_activity_i,
    // on-chip sources
    input wire logic urc_pending_i,
    input wire logic rf_cmd_i,
    input wire logic [pmc_pkg::PMC_VOLT_W-1:0] baseband_supply_i,
    // outputs
    output logic ring_ind_o,
    output logic usb_rwake_o,
    output logic rf_en_o,
    output logic sim_en_o,
    output logic serial_en_o,
    output logic sw_run_o,
    output logic sleep_o,
    output logic host_asleep_o,
    output logic rf_cmd_reject_o
);
    import pmc_pkg::*;

    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    logic dtr_s, rfdis_b_s, rdy_s, vbus_s, susp_s, usbact_s;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // pull-up defaults: dtr, rf-disable and vbus idle high; ready idles low
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 6'h0b; // RULE_18
            pin_s2_r <= 6'h0b;
        end else begin
            pin_s1_r <= {usb_rx_activity_i, usb_suspend_i, usb_vbus_i,
                         host_ready_in_i, rf_disable_b_i, dtr_i}; // RULE_19
            pin_s2_r <= pin_s1_r;
        end
    end
    assign dtr_s = pin_s2_r[0];
    assign rfdis_b_s = pin_s2_r[1];
    assign rdy_s = pin_s2_r[2];
    assign vbus_s = pin_s2_r[3];
    assign susp_s = pin_s2_r[4];
    assign usbact_s = pin_s2_r[5];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [8:0] ctrl_r;
    logic [2:0] fun_r;
    logic [PMC_IRQ_W-1:0] irq_r, mask_r, irq_set;
    logic [PMC_IRQ_W-1:0] irq_nxt;
    logic [PMC_DATA_W-1:0] rdata_nxt;
    logic req, wr, rd, wr_ctrl, wr_fun, wr_irq, wr_mask;
    logic fun_ok;
    logic sleep_en, pin_air_en, rdy_pol;
    pmc_usb_mode_t usb_mode;

    assign req = (avs_read_i | avs_write_i) & avs_waitrequest_o;
    assign wr = req & avs_write_i & avs_byteenable_i[0];
    assign rd = req & avs_read_i;
    assign wr_ctrl = wr & (avs_address_i == PMC_CTRL_ADDR);
    assign wr_fun = wr & (avs_address_i == PMC_FUNC_ADDR);
    assign wr_irq = wr & (avs_address_i == PMC_IRQ_ADDR);
    assign wr_mask = wr & (avs_address_i == PMC_MASK_ADDR);
    // only 0, 1 and 4 are accepted; anything else leaves the level
    assign fun_ok = (avs_writedata_i[2:0] == PMC_FUN_MIN) |
                    (avs_writedata_i[2:0] == PMC_FUN_FULL) |
                    (avs_writedata_i[2:0] == PMC_FUN_AIR); // RULE_12
    assign sleep_en = ctrl_r[PMC_CTRL_SLEEP_EN_BIT];
    assign pin_air_en = ctrl_r[PMC_CTRL_PIN_AIR_EN_BIT];
    assign rdy_pol = ctrl_r[PMC_CTRL_RDY_POL_BIT];
    assign usb_mode = pmc_usb_mode_t'(ctrl_r[PMC_CTRL_USB_MODE_LSB +: 2]);

    // one wait state: waitrequest drops for the cycle after the take
    // edge, so a held request is never taken twice
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest_o <= 1'b1;
            ctrl_r <= PMC_CTRL_RST;
            fun_r <= PMC_FUN_FULL; // RULE_12
            mask_r <= '0;
            avs_readdata_o <= '0;
        end else begin
            avs_waitrequest_o <= ~req;
            // power down is sticky: only reset leaves it
            if (wr_ctrl) begin
                ctrl_r <= {ctrl_r[PMC_CTRL_PWRDN_BIT] | (avs_byteenable_i[1]
                           & avs_writedata_i[PMC_CTRL_PWRDN_BIT]),
                           avs_writedata_i[7:0]}; // RULE_11
            end
            if (wr_fun && fun_ok) begin
                fun_r <= avs_writedata_i[2:0];
            end
            if (wr_mask) begin
                mask_r <= avs_writedata_i[PMC_IRQ_W-1:0];
            end
            if (rd) begin
                avs_readdata_o <= rdata_nxt;
            end
        end
    end
    // ------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------
    pmc_state_t state_r, state_nxt, awake_st;
    logic pin_air, bus_ok, sleep_go, wake_go, was_sleep;

    assign pin_air = pin_air_en & ~rfdis_b_s; // RULE_10
    assign awake_st = (fun_r == PMC_FUN_MIN) ? PMC_ST_MIN :
                      ((fun_r == PMC_FUN_AIR) || pin_air) ? PMC_ST_AIR :
                      PMC_ST_FULL; // RULE_13
    // suspend for usb hosts, lost bus power for hosts without suspend
    assign bus_ok = (usb_mode == PMC_USB_NONE) ? 1'b1 :
                    (usb_mode == PMC_USB_NOSUSP) ? ~vbus_s : susp_s; // RULE_05
    // a live wake source blocks entry, else sleep and wake would bounce
    assign sleep_go = sleep_en & dtr_s & bus_ok & ~wake_go; // RULE_01
    assign wake_go = ~dtr_s | // RULE_02
                     ((usb_mode == PMC_USB_RWAKE ||
                       usb_mode == PMC_USB_RI) & usbact_s) | // RULE_07
                     ((usb_mode == PMC_USB_NOSUSP) & vbus_s); // RULE_09

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PMC_ST_DOWN: state_nxt = PMC_ST_DOWN;
            PMC_ST_SLEEP: begin
                if (wake_go || !sleep_en) begin
                    state_nxt = awake_st;
                end
            end
            PMC_ST_FULL, PMC_ST_MIN, PMC_ST_AIR: begin
                state_nxt = sleep_go ? PMC_ST_SLEEP : awake_st;
            end
            default: state_nxt = PMC_ST_FULL;
        endcase
        if (ctrl_r[PMC_CTRL_PWRDN_BIT]) begin
            state_nxt = PMC_ST_DOWN; // RULE_16
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= PMC_ST_FULL;
        end else begin
            state_r <= state_nxt;
        end
    end
    assign was_sleep = (state_r == PMC_ST_SLEEP);

    // ------------------------------------------------------------
    // wake of the host: ring indication or bus remote wakeup
    // ------------------------------------------------------------
    logic ri_nxt, rw_start;
    logic [$clog2(RWAKE_CYC+1)-1:0] rw_cnt_r;
    logic urc_d_r;

    assign ri_nxt = urc_pending_i & ((usb_mode == PMC_USB_NONE) | // RULE_03
                    (usb_mode == PMC_USB_RI) | // RULE_08
                    (usb_mode == PMC_USB_NOSUSP));
    assign rw_start = (usb_mode == PMC_USB_RWAKE) & urc_pending_i &
                      ~urc_d_r & susp_s; // RULE_06

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            urc_d_r <= 1'b0;
            rw_cnt_r <= '0;
        end else begin
            urc_d_r <= urc_pending_i;
            if (rw_start) begin
                rw_cnt_r <= ($clog2(RWAKE_CYC+1))'(RWAKE_CYC);
            end else if (rw_cnt_r != '0) begin
                rw_cnt_r <= rw_cnt_r - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs and interrupts
    // ------------------------------------------------------------
    logic run, rf_on, rej;
    assign run = (state_r != PMC_ST_DOWN);
    assign rf_on = (state_r == PMC_ST_FULL) | (was_sleep &
                   (awake_st == PMC_ST_FULL)); // RULE_14
    assign rej = rf_cmd_i & ~rf_on; // RULE_14
    assign irq_set = {rej, was_sleep & (state_nxt != PMC_ST_SLEEP),
                      ~was_sleep & (state_nxt == PMC_ST_SLEEP)};
    // set beats the write-one clear
    assign irq_nxt = (irq_r & ~({PMC_IRQ_W{wr_irq}} &
                     avs_writedata_i[PMC_IRQ_W-1:0])) | irq_set;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= '0;
            ring_ind_o <= 1'b0;
            usb_rwake_o <= 1'b0;
            rf_en_o <= 1'b1;
            sim_en_o <= 1'b1;
            serial_en_o <= 1'b1;
            sw_run_o <= 1'b1;
            sleep_o <= 1'b0;
            host_asleep_o <= 1'b0;
            rf_cmd_reject_o <= 1'b0;
            avs_irq_o <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
            // new status, so a clear drops the line without lag
            avs_irq_o <= |(irq_nxt & mask_r);
            ring_ind_o <= ri_nxt & run;
            usb_rwake_o <= (rw_cnt_r != '0) & run;
            rf_en_o <= rf_on & run;
            sim_en_o <= run & (state_r != PMC_ST_MIN); // RULE_13
            serial_en_o <= run; // RULE_16
            sw_run_o <= run & ~was_sleep;
            sleep_o <= was_sleep;
            host_asleep_o <= (rdy_s != rdy_pol); // RULE_04
            rf_cmd_reject_o <= rej;
        end
    end

    // positioning has no term here: it never depends on fun_r (RULE_15)
    always_comb begin
        rdata_nxt = '0;
        case (avs_address_i)
            PMC_CTRL_ADDR: rdata_nxt[8:0] = ctrl_r;
            PMC_FUNC_ADDR: rdata_nxt[2:0] = fun_r;
            PMC_STAT_ADDR: rdata_nxt[7:0] = {2'h0, rdy_s, vbus_s,
                                             dtr_s, state_r};
            PMC_IRQ_ADDR: rdata_nxt[PMC_IRQ_W-1:0] = irq_r;
            PMC_MASK_ADDR: rdata_nxt[PMC_IRQ_W-1:0] = mask_r;
            PMC_VOLT_ADDR: rdata_nxt[PMC_VOLT_W-1:0] = baseband_supply_i; // RULE_17
            default: rdata_nxt = '0;
        endcase
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_sleep_cond;
        @(posedge core_clk_i) disable iff (!rst_n)
        (state_r != PMC_ST_SLEEP) && (state_nxt == PMC_ST_SLEEP)
            |-> sleep_en && dtr_s;
    endproperty
    a_sleep_cond: assert property (p_sleep_cond) else $error("bad sleep"); // RULE_01

    property p_dtr_wake;
        @(posedge core_clk_i) disable iff (!rst_n)
        was_sleep && !dtr_s && !ctrl_r[8] |=> !was_sleep;
    endproperty
    a_dtr_wake: assert property (p_dtr_wake) else $error("no wake"); // RULE_02

    property p_pin_ignored;
        @(posedge core_clk_i) disable iff (!rst_n)
        !pin_air_en && fun_r == PMC_FUN_FULL && state_r != PMC_ST_SLEEP
            && !ctrl_r[8] && !sleep_go |=> state_r == PMC_ST_FULL;
    endproperty
    a_pin_ignored: assert property (p_pin_ignored) else $error("pin used"); // RULE_11

    property p_min_sim;
        @(posedge core_clk_i) disable iff (!rst_n)
        state_r == PMC_ST_MIN |=> !sim_en_o && !rf_en_o;
    endproperty
    a_min_sim: assert property (p_min_sim) else $error("sim on"); // RULE_13

    property p_air_rej;
        @(posedge core_clk_i) disable iff (!rst_n)
        state_r == PMC_ST_AIR && rf_cmd_i |=> rf_cmd_reject_o;
    endproperty
    a_air_rej: assert property (p_air_rej) else $error("no reject"); // RULE_14

    property p_down;
        @(posedge core_clk_i) disable iff (!rst_n)
        state_r == PMC_ST_DOWN |=> !serial_en_o && !sw_run_o;
    endproperty
    a_down: assert property (p_down) else $error("serial on"); // RULE_16

    property p_ri;
        @(posedge core_clk_i) disable iff (!rst_n)
        urc_pending_i && usb_mode == PMC_USB_RI && run |=> ring_ind_o;
    endproperty
    a_ri: assert property (p_ri) else $error("no ring"); // RULE_08

    property p_rwake;
        @(posedge core_clk_i) disable iff (!rst_n)
        rw_start && run ##1 run |=> usb_rwake_o && !ring_ind_o;
    endproperty
    a_rwake: assert property (p_rwake) else $error("no rwake"); // RULE_06
endmodule : pmc_power_mode_controller
